// ### src/dld_decoder.sv
// Display list decoder: fetches words and splits their fields.
// Assumes memory answers fetch_req with fetch_valid; pready is high.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "dld_defines.svh"
module dld_decoder
   import dld_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int IP_W   = 18
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   input  wire logic              gp0_nonzero,
   output      logic              fetch_req,
   output      logic [IP_W-1:0]   fetch_addr,
   input  wire logic              fetch_valid,
   input  wire logic [15:0]       fetch_data,
   output      logic              dec_valid,
   output      dld_op_t           dec_op,
   output      logic [2:0]        dec_index,
   output      logic [15:0]       dec_field,
   output      logic              jump_taken
);
   dld_dec_if  d ();

   dld_state_t        state;
   dld_state_t        next_state;
   logic              run;
   logic              next_run;
   logic [IP_W-1:0]   ip;
   logic [IP_W-1:0]   next_ip;
   logic [IP_W-1:0]   start;
   logic [IP_W-1:0]   next_start;
   logic [5:0]        mode;
   logic [5:0]        next_mode;
   dld_op_t           cur_op;
   dld_op_t           next_cur_op;
   logic [15:0]       cur_w0;
   logic [15:0]       next_cur_w0;
   logic [2:0]        remain;
   logic [2:0]        next_remain;
   logic              in_list;
   logic              next_in_list;
   logic              next_dec_valid;
   dld_op_t           next_dec_op;
   logic [2:0]        next_dec_index;
   logic [15:0]       next_dec_field;
   logic              next_jump_taken;
   logic [31:0]       next_prdata;

   logic              ext_mode;
   logic              take;
   logic              wr_acc;
   logic              setup;
   logic [IP_W-1:0]   ip_inc;
   logic [IP_W-1:0]   far_target;
   logic              cond_ok;
   logic              is_abs_jump;

   // Shared by pslverr and the write decode
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = (a == ADDR_W'(`DLD_REG_CTRL))   ||
                (a == ADDR_W'(`DLD_REG_START))  ||
                (a == ADDR_W'(`DLD_REG_MODE))   ||
                (a == ADDR_W'(`DLD_REG_STATUS)) ||
                (a == ADDR_W'(`DLD_REG_LAST));
   endfunction : reg_hit

   // Drops don't-care and prefix bits
   function automatic logic [15:0] operand_field(
      input dld_op_t     op,
      input logic [2:0]  idx,
      input logic [15:0] w
   );
      operand_field = w;
      unique case (op)
         op_device_reg_immediate_load:
            operand_field = {4'h0, w[11:0]};
         op_tabular_absolute_plot,
         op_tabular_relative_plot:
            operand_field = {w[15], 4'h0, w[10:0]};
         op_color_table_modify: begin
            if (idx == 3'h3 || idx == 3'h4) begin
               operand_field = {8'h00, w[7:0]};
            end
         end
         default:
            operand_field = w;
      endcase
   endfunction : operand_field

   // Any nonzero mode enables extended opcodes
   assign ext_mode   = (mode != `DLD_MODE_RESET);
   assign d.word     = fetch_data;
   assign d.ext_mode = ext_mode;

   dld_classify u_classify (
      .d (d.cls)
   );

   assign fetch_req  = run && (state != st_idle);
   assign fetch_addr = ip;
   assign take       = fetch_req && fetch_valid;
   assign pready     = 1'b1;
   assign pslverr    = psel && penable && !reg_hit(paddr);
   assign wr_acc     = psel && penable && pwrite && reg_hit(paddr);
   assign setup      = psel && !penable;

   assign ip_inc     = IP_W'(ip + IP_W'(1));
   assign far_target = ext_mode ? IP_W'({cur_w0[1:0], fetch_data})
                                : IP_W'({fetch_data[14:0]});
   assign is_abs_jump = (cur_op == op_absolute_jump) ||
                        (cur_op == op_cond_absolute_jump) ||
                        (cur_op == op_jump_and_mark);
   assign cond_ok    = gp0_nonzero ||
                       !((cur_op == op_cond_absolute_jump) ||
                         (cur_op == op_cond_relative_jump));

   always_comb begin
      next_state      = state;
      next_run        = run;
      next_ip         = ip;
      next_start      = start;
      next_mode       = mode;
      next_cur_op     = cur_op;
      next_cur_w0     = cur_w0;
      next_remain     = remain;
      next_in_list    = in_list;
      next_dec_valid  = 1'b0;
      next_dec_op     = dec_op;
      next_dec_index  = dec_index;
      next_dec_field  = dec_field;
      next_jump_taken = 1'b0;
      if (take) begin
         next_dec_valid = 1'b1;
         unique case (state)
            st_opcode: begin
               next_cur_op    = d.op;
               next_cur_w0    = fetch_data;
               next_remain    = d.n_operands;
               next_in_list   = d.is_list;
               next_dec_op    = d.op;
               next_dec_index = 3'h0;
               next_dec_field = d.field;
               next_ip        = ip_inc;
               if (d.op == op_short_relative_jump) begin
                  next_jump_taken = 1'b1;
                  if (fetch_data[8]) begin
                     next_ip = IP_W'(ip_inc -
                                     IP_W'(fetch_data[7:0]));
                  end else begin
                     next_ip = IP_W'(ip_inc +
                                     IP_W'(fetch_data[7:0]));
                  end
               end
               if (d.op == op_mode_load) begin
                  next_mode = fetch_data[5:0];
               end
               if (d.n_operands != 3'h0 || d.is_list) begin
                  next_state = st_operand;
               end
            end
            st_operand: begin
               next_dec_index = 3'(dec_index + 3'h1);
               next_dec_field = operand_field(cur_op, next_dec_index,
                                              fetch_data);
               next_ip        = ip_inc;
               if (in_list) begin
                  if (fetch_data[`DLD_BIT_LAST]) begin
                     next_state = st_opcode;
                  end
               end else begin
                  next_remain = 3'(remain - 3'h1);
                  if (remain == 3'h1) begin
                     next_state = st_opcode;
                     if (is_abs_jump && cond_ok) begin
                        next_jump_taken = 1'b1;
                        next_ip = far_target;
                        if (!ext_mode && fetch_data[15]) begin
                           next_jump_taken = 1'b0;
                           next_state = st_indirect;
                        end
                     end
                     if ((cur_op == op_relative_jump ||
                          cur_op == op_cond_relative_jump) && cond_ok)
                     begin
                        next_jump_taken = 1'b1;
                        next_ip = IP_W'(ip_inc + IP_W'({{2{fetch_data[15]}},
                                  fetch_data}));
                     end
                  end
               end
            end
            st_indirect: begin
               // Pointer word reported as an operand
               next_dec_index  = 3'(dec_index + 3'h1);
               next_dec_field  = fetch_data;
               next_ip         = IP_W'(fetch_data);
               next_jump_taken = 1'b1;
               next_state      = st_opcode;
            end
            default: begin
               next_dec_valid = 1'b0;
            end
         endcase
      end
      // Writes last: they beat a word taken alongside
      if (wr_acc) begin
         if (paddr == ADDR_W'(`DLD_REG_CTRL)) begin
            next_run = pwdata[0];
            if (pwdata[0]) begin
               next_ip    = start;
               next_state = st_opcode;
            end else begin
               next_state = st_idle;
            end
            next_jump_taken = 1'b0;
            next_dec_valid  = 1'b0;
         end
         if (paddr == ADDR_W'(`DLD_REG_START)) begin
            next_start = pwdata[IP_W-1:0];
         end
         if (paddr == ADDR_W'(`DLD_REG_MODE)) begin
            next_mode = pwdata[5:0];
         end
      end
   end

   always_comb begin
      next_prdata = prdata;
      if (setup) begin
         unique case (paddr)
            ADDR_W'(`DLD_REG_CTRL):   next_prdata = {31'h0000_0000, run};
            ADDR_W'(`DLD_REG_START):  next_prdata = 32'(start);
            ADDR_W'(`DLD_REG_MODE):   next_prdata = {26'h000_0000, mode};
            ADDR_W'(`DLD_REG_STATUS): next_prdata = {8'h00, state, 22'(ip)};
            ADDR_W'(`DLD_REG_LAST):
               next_prdata = {dec_field, 5'h00, dec_index, 2'h0, dec_op};
            default:                  next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= st_idle;
         run        <= 1'b0;
         ip         <= '0;
         start      <= '0;
         mode       <= `DLD_MODE_RESET;
         cur_op     <= op_unknown;
         cur_w0     <= 16'h0000;
         remain     <= 3'h0;
         in_list    <= 1'b0;
         dec_valid  <= 1'b0;
         dec_op     <= op_unknown;
         dec_index  <= 3'h0;
         dec_field  <= 16'h0000;
         jump_taken <= 1'b0;
         prdata     <= 32'h0000_0000;
      end else begin
         state      <= next_state;
         run        <= next_run;
         ip         <= next_ip;
         start      <= next_start;
         mode       <= next_mode;
         cur_op     <= next_cur_op;
         cur_w0     <= next_cur_w0;
         remain     <= next_remain;
         in_list    <= next_in_list;
         dec_valid  <= next_dec_valid;
         dec_op     <= next_dec_op;
         dec_index  <= next_dec_index;
         dec_field  <= next_dec_field;
         jump_taken <= next_jump_taken;
         prdata     <= next_prdata;
      end
   end
endmodule : dld_decoder

// ### src/dld_defines.svh
// Constants for the display list instruction decoder.
// Assumes 16-bit instruction words and a byte-addressed APB slave.
// How it works
// - Mark jump word: bit 15 flag, target
// - Absolute jumps, plain and far forms
// - Conditional relative jump
// - Relative jump adds second word
// - Short jump; zero increment is no-op
// - General register load from next word
// - Parameter and depth loads use eleven bits
// - Conic X load with quadrant enables
// - Extended pixel intensity load
// - Device register load masks top nibble
// - Stack pointer load, plain and far
// - Text spacing load from bits 5..0
// - Coordinate words: opcode, sign, value
// - Extended mode turns X moves into plots
// - Color table modify takes four words
// - Mode instruction loads mode register
// - Pixel block move takes six words
// - Absolute point list ends on bit 15
// - Relative point list holds increments
// - Text word gives two characters
// - Video update is an extended instruction
// - X draw and move only in mode zero
// - Extended opcodes only in extended mode
// - Flagged jump target is fetched indirectly in mode zero
`ifndef DLD_DEFINES_SVH
`define DLD_DEFINES_SVH
`define DLD_P10_JUMP      10'h008
`define DLD_P10_REL_JUMP  10'h009
`define DLD_P10_COND_JUMP 10'h00A
`define DLD_P10_COND_REL  10'h00B
`define DLD_P10_MARK_JUMP 10'h010
`define DLD_P10_DEV_LOAD  10'h030
`define DLD_P10_GP_LOAD   10'h031
`define DLD_P10_SP_LOAD   10'h032
`define DLD_P10_PIX_MOVE  10'h033
`define DLD_P10_CLUT      10'h035
`define DLD_P10_MODE      10'h03A
`define DLD_P10_UPDATE    10'h03B
`define DLD_P10_TAB_ABS   10'h03E
`define DLD_P10_TAB_REL   10'h03F
`define DLD_P10_TEXT_SP   10'h301
`define DLD_P7_SHORT_JUMP 7'h05
`define DLD_P5_DEPTH      5'h02
`define DLD_P5_PARAM      5'h03
`define DLD_P5_X_LOAD_A   5'h04
`define DLD_P5_X_LOAD_R   5'h05
`define DLD_P5_X_DRAW_A   5'h06
`define DLD_P5_X_DRAW_R   5'h07
`define DLD_P5_X_MOVE_A   5'h0A
`define DLD_P5_X_MOVE_R   5'h0B
`define DLD_P5_Y_MOVE_A   5'h0C
`define DLD_P5_Y_MOVE_R   5'h0D
`define DLD_P5_CONIC_X    5'h0E
`define DLD_BIT_LAST      15
`define DLD_BIT_TEXT      7
`define DLD_N_JUMP        3'h1
`define DLD_N_CLUT        3'h4
`define DLD_N_PIX_MOVE    3'h6
`define DLD_MODE_RESET    6'h00
`define DLD_REG_CTRL      8'h00
`define DLD_REG_START     8'h04
`define DLD_REG_MODE      8'h08
`define DLD_REG_STATUS    8'h0C
`define DLD_REG_LAST      8'h10
`endif

// ### src/dld_pkg.sv
// Types shared by decoder and classifier.
// Assumes the defines header holds the numbers.
package dld_pkg;
   typedef enum logic [5:0] {
      op_unknown, op_no_operation, op_short_relative_jump,
      op_absolute_jump, op_cond_absolute_jump, op_relative_jump,
      op_cond_relative_jump, op_jump_and_mark,
      op_gp_reg_immediate_load, op_device_reg_immediate_load,
      op_stack_pointer_load, op_param_reg_load, op_depth_attr_load,
      op_conic_x_load, op_pixel_intensity_load, op_text_spacing_load,
      op_x_absolute_load, op_x_relative_load, op_x_absolute_move,
      op_x_relative_move, op_y_absolute_move, op_y_relative_move,
      op_y_absolute_plot, op_y_relative_plot, op_x_absolute_draw,
      op_x_relative_draw, op_color_table_modify, op_pixel_block_move,
      op_tabular_absolute_plot, op_tabular_relative_plot,
      op_two_char_text, op_mode_load, op_video_ctl_update
   } dld_op_t;
   typedef enum logic [1:0] {
      st_idle, st_opcode, st_operand, st_indirect
   } dld_state_t;
endpackage : dld_pkg

// ### src/dld_dec_if.sv
// One word to the classifier and its verdict back.
// Assumes one clock; the path is combinational.
`timescale 1ns/100ps
interface dld_dec_if;
   import dld_pkg::*;
   logic [15:0] word;
   logic        ext_mode;
   dld_op_t     op;
   logic [2:0]  n_operands;
   logic        is_list;
   logic [15:0] field;
   modport cls  (input word, ext_mode,
                 output op, n_operands, is_list, field);
   modport core (output word, ext_mode,
                 input op, n_operands, is_list, field);
endinterface : dld_dec_if

// ### src/dld_classify.sv
// Classifies a first word: operation, operand count, field.
// Assumes word and mode are presented in one cycle.
`timescale 1ns/100ps
`include "dld_defines.svh"
module dld_classify
   import dld_pkg::*;
(
   dld_dec_if.cls d
);
   logic [9:0] top10;
   logic [6:0] top7;
   logic [4:0] top5;
   logic       mode0;

   assign top10 = d.word[15:6];
   assign top7  = d.word[15:9];
   assign top5  = d.word[15:11];
   assign mode0 = ~d.ext_mode;

   always_comb begin
      d.op         = op_unknown;
      d.n_operands = 3'h0;
      d.is_list    = 1'b0;
      d.field      = 16'h0000;
      // Operand bits take part in the compare only in the short jump's zero test
      if (d.word[15]) begin
         if (top10 == `DLD_P10_TEXT_SP) begin
            d.op    = op_text_spacing_load;
            d.field = {10'h000, d.word[5:0]};
         end else if (d.word[`DLD_BIT_TEXT]) begin
            d.op    = op_two_char_text;
            d.field = {1'b0, d.word[14:8], 1'b0, d.word[6:0]};
         end
      end else if (top10 == `DLD_P10_JUMP ||
                   top10 == `DLD_P10_COND_JUMP) begin
         d.op = (top10 == `DLD_P10_JUMP) ? op_absolute_jump
                                         : op_cond_absolute_jump;
         d.n_operands = `DLD_N_JUMP;
         d.field = d.ext_mode ? {14'h0000, d.word[1:0]} : 16'h0000;
      end else if (top10 == `DLD_P10_REL_JUMP) begin
         d.op = op_relative_jump;
         d.n_operands = `DLD_N_JUMP;
      end else if (top10 == `DLD_P10_COND_REL) begin
         d.op = op_cond_relative_jump;
         d.n_operands = `DLD_N_JUMP;
      end else if (top10 == `DLD_P10_MARK_JUMP) begin
         d.op = op_jump_and_mark;
         d.n_operands = `DLD_N_JUMP;
      end else if (top7 == `DLD_P7_SHORT_JUMP) begin
         d.op = (d.word[8:0] == 9'h000) ? op_no_operation
                                        : op_short_relative_jump;
         d.field = {7'h00, d.word[8:0]};
      end else if (top10 == `DLD_P10_GP_LOAD) begin
         d.op = op_gp_reg_immediate_load;
         d.n_operands = 3'h1;
         d.field = {10'h000, d.word[5:0]};
      end else if (top10 == `DLD_P10_DEV_LOAD) begin
         d.op = op_device_reg_immediate_load;
         d.n_operands = 3'h1;
         d.field = {10'h000, d.word[5:0]};
      end else if (top10 == `DLD_P10_SP_LOAD) begin
         d.op = op_stack_pointer_load;
         d.n_operands = 3'h1;
         d.field = d.ext_mode ? {14'h0000, d.word[1:0]} : 16'h0000;
      end else if (top10 == `DLD_P10_MODE) begin
         d.op = op_mode_load;
         d.field = {10'h000, d.word[5:0]};
      end else if (d.ext_mode && top10 == `DLD_P10_UPDATE) begin
         d.op = op_video_ctl_update;
      end else if (d.ext_mode && top10 == `DLD_P10_CLUT) begin
         d.op = op_color_table_modify;
         d.n_operands = `DLD_N_CLUT;
         d.field = {14'h0000, d.word[1:0]};
      end else if (d.ext_mode && top10 == `DLD_P10_PIX_MOVE) begin
         d.op = op_pixel_block_move;
         d.n_operands = `DLD_N_PIX_MOVE;
         d.field = {14'h0000, d.word[1:0]};
      end else if (d.ext_mode && (top10 == `DLD_P10_TAB_ABS ||
                                  top10 == `DLD_P10_TAB_REL)) begin
         d.op = (top10 == `DLD_P10_TAB_ABS) ? op_tabular_absolute_plot
                                            : op_tabular_relative_plot;
         d.is_list = 1'b1;
         d.field = {10'h000, d.word[5:0]};
      end else begin
         d.field = {5'h00, d.word[10:0]};
         unique case (top5)
            `DLD_P5_PARAM:   d.op = op_param_reg_load;
            `DLD_P5_DEPTH:   d.op = op_depth_attr_load;
            `DLD_P5_CONIC_X: d.op = op_conic_x_load;
            `DLD_P5_X_LOAD_A: d.op = op_x_absolute_load;
            `DLD_P5_X_LOAD_R: d.op = op_x_relative_load;
            `DLD_P5_Y_MOVE_A: d.op = op_y_absolute_move;
            `DLD_P5_Y_MOVE_R: d.op = op_y_relative_move;
            `DLD_P5_X_DRAW_A: d.op = mode0 ? op_x_absolute_draw
                                           : op_unknown;
            `DLD_P5_X_DRAW_R: d.op = mode0 ? op_x_relative_draw
                                           : op_pixel_intensity_load;
            `DLD_P5_X_MOVE_A: d.op = mode0 ? op_x_absolute_move
                                           : op_y_absolute_plot;
            `DLD_P5_X_MOVE_R: d.op = mode0 ? op_x_relative_move
                                           : op_y_relative_plot;
            default:         d.op = op_unknown;
         endcase
         if (d.ext_mode && top5 == `DLD_P5_X_DRAW_R) begin
            d.field = {8'h00, d.word[7:0]};
         end
         if (d.op == op_unknown) begin
            d.field = 16'h0000;
         end
      end
   end
endmodule : dld_classify

// ### testbench/dld_mem_model.sv
// Display memory model: serves fetches, stalls every other cycle on slow.
// Assumes the decoder takes a word at pclk rise with fetch_valid high.
`timescale 1ns/100ps
module dld_mem_model #(parameter int IP_W = 18)
(
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            slow,
   input  wire logic [IP_W-1:0] fetch_addr,
   output      logic            fetch_valid,
   output      logic [15:0]     fetch_data
);
   logic [15:0] mem [0:(1<<IP_W)-1];
   logic [15:0] last;
   // Idle words are no-ops, so a runaway fetch is harmless
   initial for (int i = 0; i < (1 << IP_W); i++) mem[i] = 16'h0A00;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_valid <= 1'b0;
         last <= 16'h0000;
      end else begin
         fetch_valid <= slow ? !fetch_valid : 1'b1;
         if (fetch_valid) last <= fetch_data;
      end
   end
   // Undriven bus shows the inverse, never a stale copy
   assign fetch_data = fetch_valid ? mem[fetch_addr] : ~last;
endmodule : dld_mem_model

// ### testbench/dld_decoder_monitor.sv
// Checker on the decoder's fetch and decode ports.
// Bound to dld_decoder; sees its top-level ports only.
`timescale 1ns/100ps
module dld_decoder_monitor
   import dld_pkg::*;
#(parameter int IP_W = 18)
(
   input logic            pclk,
   input logic            presetn,
   input logic            psel,
   input logic            gp0_nonzero,
   input logic            fetch_req,
   input logic [IP_W-1:0] fetch_addr,
   input logic            fetch_valid,
   input logic [15:0]     fetch_data,
   input logic            dec_valid,
   input dld_op_t         dec_op,
   input logic [2:0]      dec_index,
   input logic [15:0]     dec_field,
   input logic            jump_taken
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_take;
      fetch_req && fetch_valid && !psel |=> dec_valid;
   endproperty
   a_take: assert property (p_take) else $error("word lost");
   property p_pulse;
      dec_valid |-> $past(fetch_req) && $past(fetch_valid);
   endproperty
   a_pulse: assert property (p_pulse) else $error("stray word");
   property p_no_operation;
      dec_valid && dec_op == op_no_operation |-> !jump_taken;
   endproperty
   a_no_operation: assert property (p_no_operation) else $error("no_operation jumped");
   property p_short;
      dec_valid && dec_op == op_short_relative_jump |-> jump_taken &&
         fetch_addr == $past(fetch_addr) + 1'b1 + ($past(fetch_data[8]) ?
         -$past(fetch_data[7:0]) : $past(fetch_data[7:0]));
   endproperty
   a_short: assert property (p_short) else $error("short jump");
   property p_rel;
      dec_valid && dec_index == 3'h1 && dec_op == op_relative_jump |->
         fetch_addr == $past(fetch_addr) + 1'b1 +
         {{2{$past(fetch_data[15])}}, $past(fetch_data)};
   endproperty
   a_rel: assert property (p_rel) else $error("relative jump");
   property p_cond;
      dec_valid && dec_index == 3'h1 && dec_op == op_cond_relative_jump
         |-> jump_taken == $past(gp0_nonzero);
   endproperty
   a_cond: assert property (p_cond) else $error("cond jump");
   property p_text;
      dec_valid && dec_op == op_two_char_text |-> dec_field ==
         {1'b0, $past(fetch_data[14:8]), 1'b0, $past(fetch_data[6:0])};
   endproperty
   a_text: assert property (p_text) else $error("text field");
   property p_list;
      dec_valid && dec_index != 3'h0 && dec_op == op_tabular_absolute_plot
         |-> dec_field == {$past(fetch_data[15]), 4'h0,
         $past(fetch_data[10:0])};
   endproperty
   a_list: assert property (p_list) else $error("list entry");
   c_jump: cover property (jump_taken);
   c_stall: cover property (fetch_req && !fetch_valid);
   c_end: cover property (dec_valid && dec_field[15]);
endmodule : dld_decoder_monitor
bind dld_decoder dld_decoder_monitor #(.IP_W(IP_W)) dld_decoder_monitor_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .gp0_nonzero(gp0_nonzero),
   .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
   .fetch_data(fetch_data), .dec_valid(dec_valid), .dec_op(dec_op),
   .dec_index(dec_index), .dec_field(dec_field), .jump_taken(jump_taken));

// ### testbench/tb_top.sv
// Bench: APB set-up, memory model, expectation queue.
// Assumes the decoder, its checker and the memory model.
`timescale 1ns/100ps
module tb_top
   import dld_pkg::*;
;
   typedef struct {dld_op_t op; int idx, fld, jt, ea;} dld_exp_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        gp0_nonzero, fetch_req, fetch_valid, dec_valid, jump_taken;
   logic        slow, err, g;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [17:0] fetch_addr;
   logic [15:0] fetch_data, dec_field, pg [25];
   logic [10:0] r1, r2;
   logic [6:0]  c1, c2;
   logic [2:0]  dec_index;
   dld_op_t     dec_op;
   dld_exp_t    q [$], e;
   int          n_errors, comparisons, i, m;
   dld_decoder #(.ADDR_W(8), .IP_W(18)) dld_decoder_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gp0_nonzero(gp0_nonzero), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data), .dec_valid(dec_valid), .dec_op(dec_op),
      .dec_index(dec_index), .dec_field(dec_field), .jump_taken(jump_taken));
   dld_mem_model #(.IP_W(18)) dld_mem_model_inst (.pclk(pclk),
      .presetn(presetn), .slow(slow), .fetch_addr(fetch_addr),
      .fetch_valid(fetch_valid), .fetch_data(fetch_data));
   initial begin pclk = 1'b0; forever #10 pclk = ~pclk; end
   task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
      comparisons++;
      if (gv !== ev) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gv, ev);
         n_errors++;
      end
   endtask : chk
   task stop_test;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      n = 0;
      do @(posedge pclk) n++; while (pready !== 1'b1 && n < 50);
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 50) begin n_errors++; stop_test; end
   endtask : apb
   task ex(input dld_op_t op, input int idx, fld, jt, ea);
      q.push_back('{op, idx, fld, jt, ea});
   endtask : ex
   // Words beyond the queue are not checked
   always @(negedge pclk) begin
      if (presetn && dec_valid === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         chk(dec_op, e.op);
         chk(dec_index, e.idx);
         if (e.fld >= 0) chk(dec_field, e.fld);
         chk(jump_taken, e.jt);
         if (e.ea >= 0) chk(fetch_addr, e.ea);
      end
   end
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      gp0_nonzero = 0; slow = 0; presetn = 0; n_errors = 0; comparisons = 0;
      void'($urandom(92175));
      r1 = $urandom; r2 = $urandom; c1 = $urandom; c2 = $urandom; g = $urandom;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      pg = '{16'h0200, 16'h8120, 16'h0A00, 16'h0A01, 16'h0A00, 16'h0240,
         16'h0001, 16'h0A00, 16'h02C0, 16'h0001, 16'h0A00, {5'h04, r1},
         {5'h0A, r2}, {1'b1, c2, 1'b1, c1}, 16'h0F80, 16'h7C23, 16'h8456,
         16'h0D41, 16'h1234, 16'h8010, 16'h0003, 16'h0107, 16'h0EC0,
         16'h0201, 16'h0004};
      for (i = 0; i < 25; i++) dld_mem_model_inst.mem[256 + i] = pg[i];
      dld_mem_model_inst.mem[18'h120] = 16'h0102;
      apb(1'b1, 8'h04, 32'hFFFFFFFF);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h3FFFF);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      for (m = 0; m < 2; m++) begin
         apb(1'b1, 8'h08, m);
         apb(1'b1, 8'h04, m ? 32'h10C : 32'h100);
         gp0_nonzero <= g; slow <= m[0];
         if (m == 0) begin
            for (i = 0; i < 3; i++) ex(op_absolute_jump, i,
               i == 2 ? 'h0102 : -1, i == 2, i == 2 ? 'h102 : -1);
            ex(op_no_operation, 0, -1, 0, -1);
            ex(op_short_relative_jump, 0, -1, 1, 'h105);
            ex(op_relative_jump, 0, -1, 0, -1);
            ex(op_relative_jump, 1, 1, 1, 'h108);
            ex(op_cond_relative_jump, 0, -1, 0, -1);
            ex(op_cond_relative_jump, 1, 1, g, g ? 'h10B : -1);
            if (!g) ex(op_no_operation, 0, -1, 0, -1);
            ex(op_x_absolute_load, 0, r1, 0, -1);
         end
         ex(m ? op_y_absolute_plot : op_x_absolute_move, 0, r2, 0, -1);
         ex(op_two_char_text, 0, {c2, 8'h00} | c1, 0, -1);
         if (m) begin
            ex(op_tabular_absolute_plot, 0, -1, 0, -1);
            ex(op_tabular_absolute_plot, 1, 'h0423, 0, -1);
            ex(op_tabular_absolute_plot, 2, 'h8456, 0, -1);
            for (i = 0; i < 5; i++) ex(op_color_table_modify, i,
               i == 3 ? 3 : i == 4 ? 7 : -1, 0, -1);
         end else begin
            for (i = 0; i < 8; i++) ex(i == 4 ? op_depth_attr_load :
               op_unknown, 0, i == 4 ? 'h234 : -1, 0, -1);
         end
         ex(m ? op_video_ctl_update : op_unknown, 0, -1, 0, -1);
         ex(op_absolute_jump, 0, -1, 0, -1);
         ex(op_absolute_jump, 1, 4, 1, m ? 'h10004 : 'h4);
         apb(1'b1, 8'h00, 32'h1);
         for (i = 0; q.size() > 0 && i < 400; i++) @(posedge pclk);
         if (q.size() > 0) n_errors++;
         apb(1'b1, 8'h00, 32'h0);
      end
      stop_test;
   end
endmodule : tb_top
